// [core/atr_pkg.sv]
package atr_pkg;

    // memory-mapped register addresses
    localparam logic [15:0] ADDR_PORT2_DIR   = 16'hFF22;
    localparam logic [15:0] ADDR_TRIG_CTL    = 16'hFF96;
    localparam logic [15:0] ADDR_RES_LOW     = 16'hFF10;
    localparam logic [15:0] ADDR_RES_HIGH    = 16'hFF11;
    localparam logic [15:0] ADDR_SYNC0_L     = 16'hFF12;
    localparam logic [15:0] ADDR_SYNC0_H     = 16'hFF13;
    localparam logic [15:0] ADDR_SYNC0_LOW   = 16'hFF14;
    localparam logic [15:0] ADDR_SYNC1_L     = 16'hFF15;
    localparam logic [15:0] ADDR_SYNC1_H     = 16'hFF16;
    localparam logic [15:0] ADDR_SYNC1_LOW   = 16'hFF17;
    localparam logic [15:0] ADDR_CONV_MODE   = 16'hFF18;
    localparam logic [15:0] ADDR_PORT_CFG    = 16'hFF19;
    localparam logic [15:0] ADDR_CHAN_SEL    = 16'hFF1A;
    localparam logic [15:0] ADDR_PORT7_DIR   = 16'hFF27;

    // reset values
    localparam logic [7:0] PORT2_DIR_RST  = 8'hFF;
    localparam logic [7:0] PORT7_DIR_RST  = 8'hFF;
    localparam logic [7:0] TRIG_CTL_RST   = 8'h00;
    localparam logic [7:0] CONV_MODE_RST  = 8'h00;
    localparam logic [7:0] PORT_CFG_RST   = 8'h00;
    localparam logic [7:0] CHAN_SEL_RST   = 8'h00;

    // field positions and widths
    localparam int TRIG_EN_BIT     = 1;
    localparam int CAP_SEL_BIT     = 0;
    localparam int CONV_EN_BIT     = 7;
    localparam int TRIG_MODE_BIT   = 6;
    localparam int REF_SEL_BIT     = 0;
    localparam int RES_BITS        = 10;
    localparam int OPAMP_PINS      = 3;
    localparam int TRIG_CTL_USED   = 2;

    // read-back index into the result bank
    localparam logic [2:0] SEL_RES_LOW    = 3'h0;
    localparam logic [2:0] SEL_RES_HIGH   = 3'h1;
    localparam logic [2:0] SEL_SYNC0_L    = 3'h2;
    localparam logic [2:0] SEL_SYNC0_H    = 3'h3;
    localparam logic [2:0] SEL_SYNC0_LOW  = 3'h4;
    localparam logic [2:0] SEL_SYNC1_L    = 3'h5;
    localparam logic [2:0] SEL_SYNC1_H    = 3'h6;
    localparam logic [2:0] SEL_SYNC1_LOW  = 3'h7;

    typedef enum logic [1:0] {
        SRC_SOFT   = 2'h0,
        SRC_TIMER0 = 2'h1,
        SRC_TIMER1 = 2'h2
    } atr_src_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } atr_state_type;

endpackage

// [core/atr_res_if.sv]
`timescale 1ns/10ps
interface atr_res_if;
    import atr_pkg::*;
    logic        wr_valid;
    atr_src_type wr_src;
    logic [9:0]  wr_value;
    logic        rd_en;
    logic [2:0]  rd_sel;
    logic [7:0]  rd_data;

    modport ctrl (output wr_valid, output wr_src, output wr_value,
                  output rd_en, output rd_sel, input rd_data);
    modport bank (input wr_valid, input wr_src, input wr_value,
                  input rd_en, input rd_sel, output rd_data);
endinterface

// [core/atr_result_bank.sv]
`timescale 1ns/10ps
module atr_result_bank
    import atr_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    // controller side
    atr_res_if.bank   res
);
    logic [RES_BITS-1:0] norm_q;
    logic [RES_BITS-1:0] sync0_q;
    logic [RES_BITS-1:0] sync1_q;
    logic [7:0]          rd_data_q;

    // software starts touch only the normal result, timer starts their own
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            norm_q  <= '0;
            sync0_q <= '0;
            sync1_q <= '0;
        end else if (res.wr_valid) begin
            unique case (res.wr_src)
                SRC_SOFT:   norm_q  <= res.wr_value;
                SRC_TIMER0: sync0_q <= res.wr_value;
                SRC_TIMER1: sync1_q <= res.wr_value;
                default:    norm_q  <= norm_q;
            endcase
        end
    end

    // upper six bits of the sync word read as zero
    function automatic logic [7:0] sync_high(input logic [RES_BITS-1:0] v);
        sync_high = {6'h00, v[RES_BITS-1:8]};
    endfunction

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_q <= 8'h00;
        end else if (res.rd_en) begin
            unique case (res.rd_sel)
                SEL_RES_LOW:   rd_data_q <= norm_q[7:0];
                SEL_RES_HIGH:  rd_data_q <= norm_q[RES_BITS-1:2];
                SEL_SYNC0_L:   rd_data_q <= sync0_q[7:0];
                SEL_SYNC0_H:   rd_data_q <= sync_high(sync0_q);
                SEL_SYNC0_LOW: rd_data_q <= sync0_q[7:0];
                SEL_SYNC1_L:   rd_data_q <= sync1_q[7:0];
                SEL_SYNC1_H:   rd_data_q <= sync_high(sync1_q);
                SEL_SYNC1_LOW: rd_data_q <= sync1_q[7:0];
            endcase
        end
    end

    assign res.rd_data = rd_data_q;

    a_high_byte_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        res.rd_en && res.rd_sel == SEL_RES_HIGH
        |=> rd_data_q == $past(norm_q[RES_BITS-1:2]))
        else $error("high result byte not loaded from conversion");
    a_sync_word_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        res.wr_valid && res.wr_src == SRC_TIMER1 |=> sync1_q == $past(res.wr_value))
        else $error("timer sync result not loaded");
endmodule

// [core/atr_adc_ctrl.sv]
`timescale 1ns/10ps
// Operation
// - each conversion end loads result high byte with upper 8 bits; here software conversions only
// - each conversion end loads result low byte with lower 8 bits; here software conversions only
// - timer conversions fill low 10 bits of sync result, top 6 read zero
// - timer conversions also load the sync low byte register
// - reading any result register inserts one bus wait cycle
// - channel select writes get a wait cycle; no writes with clock stopped
// - conversion end interrupt pulses once the selected conversion completes
// - trigger control bit 1 enables timer 1 sync trigger, clear suppresses
// - trigger comes from ch0 compare match; software keeps ch0 as compare
// - trigger control bit 0 picks ch0 compare (0) or capture (1)
// - triggers ignored while conversion disabled, honoured once enabled
// - mode, port config and channel select writable while timer runs
// - port 2 direction bit: 0 output buffer on, 1 output buffer off
// - reset sets port 2 direction to all ones
// - port 2 pins 0 to 2 join the amplifier only when direction bit is 1
module atr_adc_ctrl
    import atr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // cpu register port, strobes held until wait drops
    input  wire logic [15:0] cpu_addr_in,
    input  wire logic        cpu_rd_in,
    input  wire logic        cpu_wr_in,
    input  wire logic [7:0]  cpu_wdata_in,
    output logic      [7:0]  cpu_rdata_out,
    output logic             cpu_wait_out,
    // timers
    input  wire logic        timer0_sync_trigger_in,
    input  wire logic        timer1_ch0_match_in,
    output logic             ch0_capture_select_out,
    // analog converter core
    input  wire logic        sar_done_in,
    input  wire logic [9:0]  sar_value_in,
    output logic             conv_start_out,
    output logic             conv_busy_out,
    output logic      [7:0]  channel_select_out,
    output logic      [7:0]  port_config_0_out,
    output logic             internal_ref_select_out,
    output logic             conversion_end_irq_out,
    // pin control
    output logic      [7:0]  port2_output_enable_out,
    output logic      [7:0]  port7_output_enable_out,
    output logic      [2:0]  opamp_connect_out
);
    atr_res_if res ();

    logic [7:0]    port2_dir_q;
    logic [7:0]    port7_dir_q;
    logic [7:0]    trig_ctl_q;
    logic [7:0]    conv_mode_q;
    logic [7:0]    port_cfg_q;
    logic [7:0]    chan_sel_q;
    logic          wait_done_q;
    logic          rd_pending_q;
    logic [7:0]    reg_rdata_q;
    logic          start_q;
    logic          irq_q;
    atr_src_type   src_q;
    atr_state_type state_q;
    logic          waited_reg;
    logic          rd_go;
    logic          wr_go;
    logic          conv_en;
    logic          trig1_valid;
    logic          trig0_valid;
    logic          soft_go;

    // true for the result registers, whose reads cost one extra bus cycle
    function automatic logic is_result(input logic [15:0] a);
        is_result = (a >= ADDR_RES_LOW) && (a <= ADDR_SYNC1_LOW);
    endfunction

    function automatic logic [2:0] result_sel(input logic [15:0] a);
        result_sel = 3'(a - ADDR_RES_LOW);
    endfunction

    // bus handshake
    assign waited_reg = (cpu_rd_in && is_result(cpu_addr_in))
                     || (cpu_wr_in && cpu_addr_in == ADDR_CHAN_SEL);
    assign cpu_wait_out = waited_reg && !wait_done_q;
    assign rd_go = cpu_rd_in && !cpu_wait_out;
    assign wr_go = cpu_wr_in && !cpu_wait_out;

    // the strobe holds through the wait, so one bit of history is enough
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wait_done_q <= 1'b0;
        end else begin
            wait_done_q <= cpu_wait_out;
        end
    end

    // writable registers; no write is blocked by the timer state
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            port2_dir_q <= PORT2_DIR_RST;
            port7_dir_q <= PORT7_DIR_RST;
            trig_ctl_q  <= TRIG_CTL_RST;
            conv_mode_q <= CONV_MODE_RST;
            port_cfg_q  <= PORT_CFG_RST;
            chan_sel_q  <= CHAN_SEL_RST;
        end else if (wr_go) begin
            unique case (cpu_addr_in)
                ADDR_PORT2_DIR: port2_dir_q <= cpu_wdata_in;
                ADDR_PORT7_DIR: port7_dir_q <= cpu_wdata_in;
                ADDR_TRIG_CTL:  trig_ctl_q  <= {6'h00, cpu_wdata_in[TRIG_CTL_USED-1:0]};
                ADDR_CONV_MODE: conv_mode_q <= cpu_wdata_in;
                ADDR_PORT_CFG:  port_cfg_q  <= cpu_wdata_in;
                ADDR_CHAN_SEL:  chan_sel_q  <= cpu_wdata_in;
                default:        port_cfg_q  <= port_cfg_q;
            endcase
        end
    end

    // read path: plain registers here, results from the bank
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_q  <= 8'h00;
            rd_pending_q <= 1'b0;
        end else begin
            rd_pending_q <= rd_go && is_result(cpu_addr_in);
            if (rd_go) begin
                unique case (cpu_addr_in)
                    ADDR_PORT2_DIR: reg_rdata_q <= port2_dir_q;
                    ADDR_PORT7_DIR: reg_rdata_q <= port7_dir_q;
                    ADDR_TRIG_CTL:  reg_rdata_q <= trig_ctl_q;
                    ADDR_CONV_MODE: reg_rdata_q <= conv_mode_q;
                    ADDR_PORT_CFG:  reg_rdata_q <= port_cfg_q;
                    ADDR_CHAN_SEL:  reg_rdata_q <= chan_sel_q;
                    default:        reg_rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign res.rd_en     = rd_go && is_result(cpu_addr_in);
    assign res.rd_sel    = result_sel(cpu_addr_in);
    assign cpu_rdata_out = rd_pending_q ? res.rd_data : reg_rdata_q;

    // trigger qualification
    assign conv_en     = conv_mode_q[CONV_EN_BIT];
    assign trig1_valid = timer1_ch0_match_in && trig_ctl_q[TRIG_EN_BIT]
                      && !trig_ctl_q[CAP_SEL_BIT]
                      && conv_en;
    assign trig0_valid = timer0_sync_trigger_in && conv_en;
    // software mode runs back to back while enabled
    assign soft_go     = conv_en && !conv_mode_q[TRIG_MODE_BIT];

    // conversion sequencer; clearing the enable abandons a conversion
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            src_q   <= SRC_SOFT;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (conv_mode_q[TRIG_MODE_BIT] && trig1_valid) begin
                        state_q <= ST_BUSY;
                        src_q   <= SRC_TIMER1;
                        start_q <= 1'b1;
                    end else if (conv_mode_q[TRIG_MODE_BIT] && trig0_valid) begin
                        state_q <= ST_BUSY;
                        src_q   <= SRC_TIMER0;
                        start_q <= 1'b1;
                    end else if (soft_go) begin
                        state_q <= ST_BUSY;
                        src_q   <= SRC_SOFT;
                        start_q <= 1'b1;
                    end
                end
                ST_BUSY: begin
                    if (!conv_en || sar_done_in) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign res.wr_valid = (state_q == ST_BUSY) && sar_done_in && conv_en;
    assign res.wr_src   = src_q;
    assign res.wr_value = sar_value_in;

    // interrupt pulse rises on the same edge the result lands
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= res.wr_valid;
        end
    end

    atr_result_bank u_bank (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .res        (res)
    );

    assign conv_start_out          = start_q;
    assign conv_busy_out           = state_q == ST_BUSY;
    assign conversion_end_irq_out  = irq_q;
    assign channel_select_out      = chan_sel_q;
    assign port_config_0_out       = port_cfg_q;
    assign internal_ref_select_out = conv_mode_q[REF_SEL_BIT];
    assign ch0_capture_select_out  = trig_ctl_q[CAP_SEL_BIT];
    assign port2_output_enable_out = ~port2_dir_q;
    assign port7_output_enable_out = ~port7_dir_q;
    assign opamp_connect_out       = port2_dir_q[OPAMP_PINS-1:0];

    a_result_read_wait: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(cpu_rd_in) && is_result(cpu_addr_in) |-> cpu_wait_out ##1 !cpu_wait_out)
        else $error("result read did not wait exactly one cycle");
    a_chsel_write_wait: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(cpu_wr_in) && cpu_addr_in == ADDR_CHAN_SEL
        |-> cpu_wait_out && $stable(chan_sel_q) ##1 !cpu_wait_out)
        else $error("channel select write did not wait");
    a_irq_after_done: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state_q == ST_BUSY && sar_done_in && conv_en |=> conversion_end_irq_out)
        else $error("conversion end without interrupt");
    a_irq_needs_done: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        conversion_end_irq_out |-> $past(sar_done_in))
        else $error("interrupt without conversion end");
    a_trig_disabled: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state_q == ST_IDLE && conv_mode_q[TRIG_MODE_BIT] && !conv_en |=> !conv_start_out)
        else $error("trigger accepted while conversion disabled");
    a_trig_gate_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        conv_start_out && src_q == SRC_TIMER1
        |-> $past(trig_ctl_q[TRIG_EN_BIT]) && !$past(trig_ctl_q[CAP_SEL_BIT]))
        else $error("timer 1 trigger passed while suppressed");
    a_trig_taken: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state_q == ST_IDLE && conv_mode_q[TRIG_MODE_BIT] && trig1_valid
        |=> conv_start_out && src_q == SRC_TIMER1)
        else $error("valid timer trigger not acted on");
    a_port2_reset: assert property (@(posedge clk_sys_in)
        $fell(rst_in) |-> port2_dir_q == PORT2_DIR_RST)
        else $error("port 2 direction not all ones after reset");
    a_opamp_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        opamp_connect_out != 3'h0 |-> (port2_output_enable_out[2:0] & opamp_connect_out) == 3'h0)
        else $error("amplifier pin connected while output buffer on");
    a_soft_dest: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        res.wr_valid |-> res.wr_src == src_q && $past(state_q) == ST_BUSY)
        else $error("result written to wrong source bank");

    c_soft_conv:  cover property (@(posedge clk_sys_in) conversion_end_irq_out && src_q == SRC_SOFT);
    c_timer1_conv: cover property (@(posedge clk_sys_in) res.wr_valid && src_q == SRC_TIMER1);
    c_result_read: cover property (@(posedge clk_sys_in) rd_pending_q);
    c_abort:      cover property (@(posedge clk_sys_in) state_q == ST_BUSY && !conv_en);
endmodule

// [sim/atr_sar_model.sv]
`timescale 1ns/10ps
// analog core stand-in: answers each start after LAT_CYC cycles
module atr_sar_model
    import atr_pkg::*;
#(
    parameter int LAT_CYC = 12
)
(
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // from controller
    input  wire logic       conv_start_in,
    input  wire logic       conv_busy_in,
    input  wire logic [9:0] value_in,
    // to controller
    output logic            sar_done_out,
    output logic      [9:0] sar_value_out
);
    logic [7:0] cnt_q;
    logic       run_q;

    // an abort (busy dropped) cancels the pending answer
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            run_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (conv_start_in) begin
            run_q <= 1'b1;
            cnt_q <= 8'(LAT_CYC);
        end else if (!conv_busy_in || (run_q && cnt_q == 8'h00)) begin
            run_q <= 1'b0;
        end else if (run_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    assign sar_done_out = run_q && conv_busy_in && (cnt_q == 8'h00);
    // value is only meaningful with done; otherwise it churns each cycle of the countdown
    assign sar_value_out = sar_done_out ? value_in : ~(value_in ^ {2'b00, cnt_q});
endmodule

// [sim/tb_adc_result_and_timer_trigger.sv]
`timescale 1ns/10ps
`define CHECK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
module tb_adc_result_and_timer_trigger;
    import atr_pkg::*;
    logic        clk_sys_in;
    logic        rst_in;
    logic [15:0] cpu_addr;
    logic        cpu_rd;
    logic        cpu_wr;
    logic [7:0]  cpu_wdata;
    logic [7:0]  cpu_rdata;
    logic        cpu_wait;
    logic        tmr0_trig;
    logic        tmr1_match;
    logic        ch0_cap;
    logic        sar_done;
    logic [9:0]  sar_value;
    logic [9:0]  sar_val;
    logic        conv_start;
    logic        conv_busy;
    logic [7:0]  chan_sel;
    logic [7:0]  port_cfg;
    logic        conv_irq;
    logic [7:0]  port2_oe;
    logic [7:0]  port7_oe;
    logic        ref_sel;
    logic [2:0]  opamp;
    logic [7:0]  exp_q[$];
    logic        pend = 1'b0;
    logic [31:0] rnd;
    logic [9:0]  sv;
    logic [7:0]  dv;
    logic [15:0] base;
    int          num_errors;
    int          n_tests;

    atr_adc_ctrl dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cpu_addr_in(cpu_addr),
        .cpu_rd_in(cpu_rd), .cpu_wr_in(cpu_wr), .cpu_wdata_in(cpu_wdata),
        .cpu_rdata_out(cpu_rdata), .cpu_wait_out(cpu_wait), .timer0_sync_trigger_in(tmr0_trig),
        .timer1_ch0_match_in(tmr1_match), .ch0_capture_select_out(ch0_cap),
        .sar_done_in(sar_done), .sar_value_in(sar_value), .conv_start_out(conv_start),
        .conv_busy_out(conv_busy), .channel_select_out(chan_sel), .port_config_0_out(port_cfg),
        .internal_ref_select_out(ref_sel), .conversion_end_irq_out(conv_irq),
        .port2_output_enable_out(port2_oe), .port7_output_enable_out(port7_oe),
        .opamp_connect_out(opamp));

    atr_sar_model #(.LAT_CYC(12)) far (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .conv_start_in(conv_start), .conv_busy_in(conv_busy), .value_in(sar_val),
        .sar_done_out(sar_done), .sar_value_out(sar_value));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // strobe held until the edge after wait has dropped
    task automatic bus_op(input logic is_wr, input logic [15:0] a, input logic [7:0] d,
                          input logic exp_wait);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        cpu_addr  <= a;
        cpu_wdata <= d;
        if (is_wr) cpu_wr <= 1'b1;
        else cpu_rd <= 1'b1;
        @(negedge clk_sys_in);
        `CHECK(cpu_wait, exp_wait)
        while (cpu_wait === 1'b1 && n < 4) begin
            @(negedge clk_sys_in);
            n++;
        end
        @(posedge clk_sys_in);
        cpu_rd <= 1'b0;
        cpu_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic w);
        exp_q.push_back(e);
        bus_op(1'b0, a, 8'h00, w);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic w);
        bus_op(1'b1, a, d, w);
    endtask

    task automatic pulse(input logic tmr1);
        @(posedge clk_sys_in);
        if (tmr1) tmr1_match <= 1'b1;
        else tmr0_trig <= 1'b1;
        @(posedge clk_sys_in);
        tmr1_match <= 1'b0;
        tmr0_trig  <= 1'b0;
    endtask

    task automatic expect_start(input logic e);
        logic seen;
        seen = 1'b0;
        repeat (4) begin
            @(negedge clk_sys_in);
            if (conv_start === 1'b1) seen = 1'b1;
        end
        `CHECK(seen, e)
    endtask

    task automatic wait_irq;
        int n;
        n = 0;
        @(negedge clk_sys_in);
        while (conv_irq !== 1'b1 && n < 200) begin
            @(negedge clk_sys_in);
            n++;
        end
        `CHECK(conv_irq, 1'b1)
        @(negedge clk_sys_in);
        `CHECK(conv_irq, 1'b0)
    endtask

    // read data lands the cycle after the taking edge
    always @(negedge clk_sys_in) begin
        logic [7:0] e;
        if (pend) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("ERROR t=%0t read with no expectation", $time);
            end else begin
                e = exp_q.pop_front();
                `CHECK(cpu_rdata, e)
            end
        end
        pend = (cpu_rd === 1'b1) && (cpu_wait === 1'b0);
    end

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // whole run is just over a thousand cycles
    initial begin
        #200000;
        num_errors++;
        final_report();
    end

    initial begin
        rst_in = 1'b1;
        cpu_addr = 16'h0000;
        cpu_rd = 1'b0;
        cpu_wr = 1'b0;
        cpu_wdata = 8'h00;
        tmr0_trig = 1'b0;
        tmr1_match = 1'b0;
        sar_val = 10'h000;
        rnd = 32'h3c6e;
        num_errors = 0;
        n_tests = 0;
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(negedge clk_sys_in);
        `CHECK(port2_oe, 8'h00)
        `CHECK(port7_oe, 8'h00)
        `CHECK(opamp, 3'h7)
        `CHECK(ref_sel, 1'b0)
        rd(ADDR_PORT2_DIR, PORT2_DIR_RST, 1'b0);
        rd(ADDR_TRIG_CTL, TRIG_CTL_RST, 1'b0);
        rd(ADDR_PORT7_DIR, PORT7_DIR_RST, 1'b0);
        rd(16'hFF00, 8'h00, 1'b0);
        rnd = lfsr_next(rnd);
        // bits 7 and 6 kept set so the value is legal on every variant
        dv = rnd[7:0] | 8'hC0;
        wr(ADDR_PORT2_DIR, dv, 1'b0);
        @(negedge clk_sys_in);
        `CHECK(port2_oe, ~dv)
        `CHECK(opamp, dv[2:0])
        rd(ADDR_PORT2_DIR, dv, 1'b0);
        // no timer pulses in flight, so the control bits may change
        wr(ADDR_TRIG_CTL, 8'hFF, 1'b0);
        rd(ADDR_TRIG_CTL, 8'h03, 1'b0);
        `CHECK(ch0_cap, 1'b1)
        wr(ADDR_PORT_CFG, 8'h3C, 1'b0);
        wr(ADDR_CHAN_SEL, 8'h05, 1'b1);
        // write lands on the edge the task returns on
        @(negedge clk_sys_in);
        `CHECK(port_cfg, 8'h3C)
        `CHECK(chan_sel, 8'h05)
        // reference picked while stopped, settle time before enabling
        wr(ADDR_CONV_MODE, 8'h01, 1'b0);
        @(negedge clk_sys_in);
        `CHECK(ref_sel, 1'b1)
        repeat (1000) @(posedge clk_sys_in);
        // software conversion, then stopped before the restart completes
        rnd = lfsr_next(rnd);
        sv = rnd[9:0];
        sar_val = sv;
        wr(ADDR_CONV_MODE, 8'h81, 1'b0);
        wait_irq();
        wr(ADDR_CONV_MODE, 8'h00, 1'b0);
        // clock never stops in this bench, so result reads are legal
        rd(ADDR_RES_HIGH, sv[9:2], 1'b1);
        rd(ADDR_RES_LOW, sv[7:0], 1'b1);
        // capture selected: match must not trigger
        wr(ADDR_CONV_MODE, 8'hC0, 1'b0);
        pulse(1'b1);
        expect_start(1'b0);
        wr(ADDR_TRIG_CTL, 8'h00, 1'b0);
        pulse(1'b1);
        expect_start(1'b0);
        wr(ADDR_TRIG_CTL, 8'h02, 1'b0);
        for (int t = 0; t < 2; t++) begin
            rnd = lfsr_next(rnd);
            sv = rnd[9:0];
            sar_val = sv;
            base = (t == 1) ? ADDR_SYNC1_L : ADDR_SYNC0_L;
            pulse(t[0]);
            expect_start(1'b1);
            `CHECK(conv_busy, 1'b1)
            wait_irq();
            `CHECK(conv_busy, 1'b0)
            rd(base, sv[7:0], 1'b1);
            rd(base + 16'h0001, {6'h00, sv[9:8]}, 1'b1);
            rd(base + 16'h0002, sv[7:0], 1'b1);
        end
        wr(ADDR_CONV_MODE, 8'h40, 1'b0);
        pulse(1'b0);
        expect_start(1'b0);
        wr(ADDR_CONV_MODE, 8'hC0, 1'b0);
        pulse(1'b0);
        expect_start(1'b1);
        wait_irq();
        repeat (5) @(posedge clk_sys_in);
        final_report();
    end
endmodule
